// File: src/rsq_pkg.sv
// Notes on behaviour
// (RQ1) enabled pin held low past minimum resets
// (RQ2) after pin release, stretch then run
// (RQ3) fuses choose the stretch period length
// (RQ4) level fuse 111 disables undervoltage detection
// (RQ5) undervoltage holds reset, releases after stretch
// (RQ6) undervoltage shorter than minimum time ignored
// (RQ7) watchdog time-out gives one-cycle reset pulse
// (RQ8) stretch starts as watchdog pulse ends
// (RQ9) cause register at 0x34 and 0x54
// (RQ10) upper four cause bits read zero
// (RQ11) watchdog flag set by watchdog, write-zero clears
// (RQ12) undervoltage flag set by undervoltage, write-zero clears
// (RQ13) pin flag set by pin reset
// (RQ14) powerup flag cleared only by software
// (RQ15) software reads then clears flags early
// (RQ16) reference on for detector, comparator or converter
// (RQ17) hold reset below powerup threshold, then stretch
// (RQ18) set beats simultaneous software clear
package rsq_pkg;

    localparam int unsigned CLK_PERIOD_NS    = 25;
    localparam int unsigned PIN_MIN_NS       = 900;
    localparam int unsigned PIN_MIN_CYC      = (PIN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned UV_MIN_NS        = 2000;
    localparam int unsigned UV_MIN_CYC       = (UV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRETCH_MIN_NS   = 150;
    localparam int unsigned STRETCH_MIN_CYC  =
        (STRETCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRETCH_SHORT_NS = 4100000;
    localparam int unsigned STRETCH_SHORT_CYC =
        (STRETCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STRETCH_LONG_NS  = 65000000;
    localparam int unsigned STRETCH_LONG_CYC =
        (STRETCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned STRETCH_W = 22;
    localparam int unsigned FILT_W    = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned FLAG_W    = 4;

    localparam logic [STRETCH_W-1:0] STRETCH_ONE = 22'h000001;
    localparam logic [STRETCH_W-1:0] STRETCH_ZERO = 22'h000000;

    localparam logic [ADDR_W-1:0] CAUSE_IO_ADDR   = 8'h34;
    localparam logic [ADDR_W-1:0] CAUSE_DATA_ADDR = 8'h54;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 8'h35;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR  = 8'h36;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 8'h37;

    localparam int unsigned FLAG_POWERUP = 0;
    localparam int unsigned FLAG_PIN     = 1;
    localparam int unsigned FLAG_UV      = 2;
    localparam int unsigned FLAG_WDOG    = 3;

    localparam logic [FLAG_W-1:0] CAUSE_RESET  = 4'h1;
    localparam logic [FLAG_W-1:0] IRQ_RESET    = 4'h0;
    localparam logic [2:0]        UV_OFF_CODE  = 3'h7;
    localparam logic [1:0]        SUT_MIN_CODE = 2'h0;
    localparam logic [1:0]        SUT_SHORT_CODE = 2'h1;
    localparam logic [3:0]        CLOCK_SELECT_FUSE_EXT_CODE = 4'h0;

    typedef struct packed {
        logic [2:0] undervoltageLevelFuse;
        logic [1:0] startupTimeFuse;
        logic [3:0] clockSelectFuse;
    } rsq_fuse_s;

    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_HOLD    = 4'h2,
        ST_WDOG    = 4'h4,
        ST_STRETCH = 4'h8
    } rsq_state_e;

    function automatic logic isCauseAddr(input logic [ADDR_W-1:0] a);
        return (a == CAUSE_IO_ADDR) || (a == CAUSE_DATA_ADDR);
    endfunction : isCauseAddr

endpackage : rsq_pkg

// File: src/rsq_level_filter.sv
`timescale 1ns/1ps
module rsq_level_filter import rsq_pkg::*; #(
    parameter int unsigned HOLD_CYC = 2,
    parameter logic        ACT_LVL  = 1'b1
) (
    // clock and control
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic clkEn,
    // raw level from outside the clock domain
    input  wire logic rawIn,
    // qualified level
    output logic      level
);

    localparam logic [FILT_W-1:0] LAST = FILT_W'(HOLD_CYC - 1);

    logic              syncA;
    logic              syncB;
    logic [FILT_W-1:0] runCnt;
    logic [FILT_W-1:0] next_runCnt;
    logic              next_level;
    logic              active;

    assign active = (syncB == ACT_LVL);

    // glitches shorter than the hold time never reach level
    always_comb begin
        next_runCnt = runCnt;
        next_level  = level;
        if (!active) begin
            next_runCnt = '0;
            next_level  = 1'b0;
        end else if (runCnt == LAST) begin
            next_level = 1'b1; // RQ6
        end else begin
            next_runCnt = runCnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            syncA  <= ~ACT_LVL;
            syncB  <= ~ACT_LVL;
            runCnt <= '0;
            level  <= 1'b0;
        end else if (clkEn) begin
            syncA  <= rawIn;
            syncB  <= syncA;
            runCnt <= next_runCnt;
            level  <= next_level;
        end
    end

    chk_min_width_held: assert property (@(posedge ref_clk) disable iff (!rstn || !clkEn) // RQ6
        $rose(level) |-> ($past(runCnt) == LAST))
        else $error("filtered level rose before minimum width");

endmodule : rsq_level_filter

// File: src/rsq_reset_sequencer.sv
`timescale 1ns/1ps
module rsq_reset_sequencer import rsq_pkg::*; #(
    parameter int unsigned STRETCH_SHORT_CYCLES = STRETCH_SHORT_CYC,
    parameter int unsigned STRETCH_LONG_CYCLES  = STRETCH_LONG_CYC
) (
    // clock, powerup reset, enable
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              clkEn,
    // fuses
    input  wire rsq_fuse_s         fuses,
    // reset sources
    input  wire logic              resetPinN,
    input  wire logic              pinResetEnable,
    input  wire logic              undervoltageBelow,
    input  wire logic              watchdogTimeout,
    // reference consumers
    input  wire logic              comparatorRefSelect,
    input  wire logic              adcEnable,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // results
    output logic                   coreResetN,
    output logic                   watchdogResetPulse,
    output logic                   refEnable,
    output logic                   irq
);

    rsq_state_e            state;
    rsq_state_e            next_state;
    logic [STRETCH_W-1:0]  stretchCnt;
    logic [STRETCH_W-1:0]  next_stretchCnt;
    logic [STRETCH_W-1:0]  stretchTarget;
    logic [STRETCH_W-1:0]  stretchLast;
    logic [FLAG_W-1:0]     causeFlags;
    logic [FLAG_W-1:0]     next_causeFlags;
    logic [FLAG_W-1:0]     causeSet;
    logic [FLAG_W-1:0]     irqStatus;
    logic [FLAG_W-1:0]     next_irqStatus;
    logic [FLAG_W-1:0]     irqEnable;
    logic [FLAG_W-1:0]     next_irqEnable;
    logic [FLAG_W-1:0]     irqEvents;
    logic [DATA_W-1:0]     next_regRdata;
    logic                  next_irq;
    logic                  next_refEnable;
    logic                  pinLow;
    logic                  uvLow;
    logic                  uvEnabled;
    logic                  pinRst;
    logic                  uvRst;
    logic                  srcActive;
    logic                  wdtEvent;
    logic                  refNeed;
    logic                  causeWr;
    logic                  porClearReq;

    // pin qualified by minimum low width; async pin level is synchronised inside
    rsq_level_filter #(
        .HOLD_CYC (PIN_MIN_CYC),
        .ACT_LVL  (1'b0)
    ) u_pin_filter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .rawIn   (resetPinN),
        .level   (pinLow)
    );

    rsq_level_filter #(
        .HOLD_CYC (UV_MIN_CYC),
        .ACT_LVL  (1'b1)
    ) u_uv_filter (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .clkEn   (clkEn),
        .rawIn   (undervoltageBelow),
        .level   (uvLow)
    );

    assign uvEnabled = (fuses.undervoltageLevelFuse != UV_OFF_CODE); // RQ4
    assign pinRst    = pinResetEnable && pinLow; // RQ1
    assign uvRst     = uvEnabled && uvLow; // RQ5
    assign srcActive = pinRst || uvRst;
    // a watchdog time-out only counts while the core is running
    assign wdtEvent  = watchdogTimeout && (state == ST_RUN);
    assign refNeed   = uvEnabled || comparatorRefSelect || adcEnable;
    assign causeWr   = regWr && isCauseAddr(regAddr); // RQ9
    assign porClearReq = causeWr && !regWdata[FLAG_POWERUP];

    // stretch length from start-up and clock-select fuses
    function automatic logic [STRETCH_W-1:0] stretchSel(input rsq_fuse_s f);
        if (f.startupTimeFuse == SUT_MIN_CODE) begin
            return STRETCH_W'(STRETCH_MIN_CYC);
        end else if ((f.startupTimeFuse == SUT_SHORT_CODE)
                     || (f.clockSelectFuse == CLOCK_SELECT_FUSE_EXT_CODE)) begin
            return STRETCH_W'(STRETCH_SHORT_CYCLES);
        end else begin
            return STRETCH_W'(STRETCH_LONG_CYCLES);
        end
    endfunction : stretchSel

    assign stretchTarget = stretchSel(fuses); // RQ3
    assign stretchLast   = stretchTarget - STRETCH_ONE;

    // sequencer
    always_comb begin
        next_state      = state;
        next_stretchCnt = stretchCnt;
        case (state)
            ST_RUN: begin
                if (srcActive) begin
                    next_state = ST_HOLD; // RQ1
                end else if (wdtEvent) begin
                    next_state = ST_WDOG; // RQ7
                end
            end
            ST_HOLD: begin
                if (!srcActive) begin
                    next_state      = ST_STRETCH; // RQ2
                    next_stretchCnt = STRETCH_ZERO;
                end
            end
            ST_WDOG: begin
                // counting begins as the one-cycle pulse ends
                next_state      = srcActive ? ST_HOLD : ST_STRETCH; // RQ8
                next_stretchCnt = STRETCH_ZERO;
            end
            ST_STRETCH: begin
                if (srcActive) begin
                    next_state = ST_HOLD; // RQ5
                end else if (stretchCnt >= stretchLast) begin
                    next_state = ST_RUN; // RQ2
                end else begin
                    next_stretchCnt = stretchCnt + STRETCH_ONE;
                end
            end
            default: begin
                next_state      = ST_HOLD;
                next_stretchCnt = STRETCH_ZERO;
            end
        endcase
    end

    // powerup reset lands in stretch, so release always waits the full period
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= ST_STRETCH; // RQ17
            stretchCnt <= STRETCH_ZERO;
        end else if (clkEn) begin
            state      <= next_state;
            stretchCnt <= next_stretchCnt;
        end
    end

    assign coreResetN         = (state == ST_RUN);
    assign watchdogResetPulse = (state == ST_WDOG);

    // flags, interrupt state and read port
    always_comb begin
        causeSet               = '0;
        causeSet[FLAG_PIN]     = pinRst; // RQ13
        causeSet[FLAG_UV]      = uvRst; // RQ12
        causeSet[FLAG_WDOG]    = wdtEvent && !srcActive; // RQ11
        irqEvents              = causeSet & {FLAG_W{state == ST_RUN}};
        irqEvents[FLAG_POWERUP] = (state == ST_STRETCH) && (next_state == ST_RUN);
        next_causeFlags        = causeFlags;
        next_irqStatus         = irqStatus;
        next_irqEnable         = irqEnable;
        for (int i = 0; i < FLAG_W; i++) begin
            // cause write of zero clears, irq clear write of one clears; an event in the same cycle wins
            if (causeWr && !regWdata[i]) begin
                next_causeFlags[i] = 1'b0; // RQ11
            end
            if (regWr && (regAddr == IRQ_CLEAR_ADDR) && regWdata[i]) begin
                next_irqStatus[i] = 1'b0;
            end
            next_causeFlags[i] = next_causeFlags[i] | causeSet[i]; // RQ18
            next_irqStatus[i]  = next_irqStatus[i] | irqEvents[i];
        end
        if (regWr && (regAddr == IRQ_ENABLE_ADDR)) begin
            next_irqEnable = regWdata[FLAG_W-1:0];
        end
        next_regRdata = '0;
        if (regRd) begin
            if (isCauseAddr(regAddr)) begin
                next_regRdata = {4'h0, causeFlags}; // RQ10
            end else if (regAddr == IRQ_STATUS_ADDR) begin
                next_regRdata = {4'h0, irqStatus};
            end else if (regAddr == IRQ_ENABLE_ADDR) begin
                next_regRdata = {4'h0, irqEnable};
            end
        end
        next_irq       = |(next_irqStatus & next_irqEnable);
        next_refEnable = refNeed; // RQ16
    end

    // only the powerup reset touches the cause flags, so bit 0 survives others
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            causeFlags <= CAUSE_RESET; // RQ14
            irqStatus  <= IRQ_RESET;
            irqEnable  <= IRQ_RESET;
            regRdata   <= '0;
            irq        <= 1'b0;
            refEnable  <= 1'b0;
        end else if (clkEn) begin
            causeFlags <= next_causeFlags;
            irqStatus  <= next_irqStatus;
            irqEnable  <= next_irqEnable;
            regRdata   <= next_regRdata;
            irq        <= next_irq;
            refEnable  <= next_refEnable;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn || !clkEn);

    sequence seq_wdog_step;
        watchdogResetPulse ##1 (!watchdogResetPulse && (state == ST_STRETCH)
                                && (stretchCnt == STRETCH_ZERO));
    endsequence

    sequence seq_source_seen;
        (state == ST_RUN) && srcActive;
    endsequence

    chk_wdog_pulse_once: assert property ( // RQ7
        (wdtEvent && !srcActive) |=> watchdogResetPulse ##1 !watchdogResetPulse)
        else $error("watchdog reset pulse not exactly one cycle");

    chk_wdog_stretch_start: assert property ( // RQ8
        (wdtEvent && !srcActive) ##1 !srcActive |-> seq_wdog_step)
        else $error("stretch did not start after watchdog pulse");

    chk_stretch_release: assert property ( // RQ2
        ((state == ST_STRETCH) && !srcActive && (stretchCnt == stretchLast))
        |=> coreResetN)
        else $error("core not released at end of stretch");

    chk_stretch_early: assert property ( // RQ2
        ((state == ST_STRETCH) && (stretchCnt < stretchLast)) |=> !coreResetN)
        else $error("core released before stretch ended");

    chk_pin_holds_reset: assert property ( // RQ1
        pinRst |=> !coreResetN)
        else $error("pin reset did not hold the core");

    chk_uv_holds_reset: assert property ( // RQ5
        uvRst |=> !coreResetN ##1 !coreResetN)
        else $error("undervoltage reset did not hold the core");

    chk_source_enters_hold: assert property ( // RQ5
        seq_source_seen |=> (state == ST_HOLD))
        else $error("running core ignored an active source");

    chk_uv_off_code: assert property ( // RQ4
        ((fuses.undervoltageLevelFuse == UV_OFF_CODE) && (state == ST_RUN) && !pinRst
         && !wdtEvent) |=> coreResetN)
        else $error("undervoltage reset while detection disabled");

    chk_stretch_select: assert property ( // RQ3
        (fuses.startupTimeFuse == SUT_MIN_CODE)
        |-> (stretchTarget == STRETCH_W'(STRETCH_MIN_CYC)))
        else $error("stretch length does not follow fuses");

    chk_cause_upper_zero: assert property ( // RQ10
        (regRd && isCauseAddr(regAddr)) |=> (regRdata[7:4] == 4'h0)
                                            && (regRdata[3:0] == $past(causeFlags)))
        else $error("cause register read wrong");

    chk_wdog_flag_set: assert property ( // RQ11
        (wdtEvent && !srcActive) |=> causeFlags[FLAG_WDOG])
        else $error("watchdog flag not set");

    chk_uv_flag_set: assert property ( // RQ12
        uvRst |=> causeFlags[FLAG_UV])
        else $error("undervoltage flag not set");

    chk_pin_flag_set: assert property ( // RQ13
        pinRst |=> causeFlags[FLAG_PIN])
        else $error("pin flag not set");

    chk_powerup_clear: assert property ( // RQ14
        $fell(causeFlags[FLAG_POWERUP]) |-> $past(porClearReq))
        else $error("powerup flag cleared without software write");

    chk_set_beats_clear: assert property ( // RQ18
        (causeWr && !regWdata[FLAG_PIN] && pinRst) |=> causeFlags[FLAG_PIN])
        else $error("clear won over a pin event");

    chk_ref_enable: assert property ( // RQ16
        refNeed |=> refEnable)
        else $error("reference not enabled while needed");

    chk_ref_disable: assert property ( // RQ16
        !refNeed |=> !refEnable)
        else $error("reference enabled while unused");

endmodule : rsq_reset_sequencer

// File: verification/rsq_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
module rsq_reset_sequencer_tb_top import rsq_pkg::*;;
    typedef struct packed {
        logic [2:0] lvl;
        logic [1:0] startup_time_fuse;
        logic [3:0] cks;
        logic [7:0] target;
    } rsq_row_s;

    // clock and reset
    logic              ref_clk;
    logic              rstn;
    logic              clkEn;
    // sources and fuses
    rsq_fuse_s         fuses;
    logic              resetPinN;
    logic              pinResetEnable;
    logic              undervoltageBelow;
    logic              watchdogTimeout;
    logic              comparatorRefSelect;
    logic              adcEnable;
    // register port
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdata;
    // results
    logic              coreResetN;
    logic              watchdogResetPulse;
    logic              refEnable;
    logic              irq;
    int                n_mismatch;
    int                cmp_count;
    rsq_row_s          rows [8];

    // short stretch counts keep the run brief
    rsq_reset_sequencer #(.STRETCH_SHORT_CYCLES(20), .STRETCH_LONG_CYCLES(40)) rsq_reset_sequencer_i (
        .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .fuses(fuses),
        .resetPinN(resetPinN), .pinResetEnable(pinResetEnable),
        .undervoltageBelow(undervoltageBelow), .watchdogTimeout(watchdogTimeout),
        .comparatorRefSelect(comparatorRefSelect), .adcEnable(adcEnable),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .coreResetN(coreResetN),
        .watchdogResetPulse(watchdogResetPulse), .refEnable(refEnable), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        @(negedge ref_clk);
        chk("regRdata", regRdata, exp);
    endtask : rd

    task automatic por();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask : por

    // counts held cycles; slack covers the filter latency of slow sources
    task automatic run_wait(input int lo, input int hi);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (coreResetN !== 1'b1 && n < 300) begin
            n++;
            @(negedge ref_clk);
        end
        chk("stretch", 8'(n >= lo && n <= hi), 8'h01);
    endtask : run_wait

    task automatic hold_src(input int cyc, input bit pin, input logic [7:0] expCore);
        @(posedge ref_clk);
        if (pin) resetPinN <= 1'b0;
        else undervoltageBelow <= 1'b1;
        repeat (cyc) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("coreResetN", coreResetN, expCore);
        @(posedge ref_clk);
        resetPinN         <= 1'b1;
        undervoltageBelow <= 1'b0;
    endtask : hold_src

    initial begin
        #(20000 * 25);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        n_mismatch = 0;
        cmp_count  = 0;
        rstn = 1'b0;
        clkEn = 1'b1;
        fuses = '{3'h6, 2'h0, 4'h5};
        {resetPinN, pinResetEnable, undervoltageBelow, watchdogTimeout} = 4'h8;
        {comparatorRefSelect, adcEnable, regWr, regRd} = 4'h0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
        rows = '{'{3'h6, 2'h0, 4'h5, 8'h06}, '{3'h5, 2'h1, 4'h5, 8'h14},
                 '{3'h3, 2'h2, 4'h0, 8'h14}, '{3'h0, 2'h2, 4'h5, 8'h28},
                 '{3'h7, 2'h3, 4'h3, 8'h28}, '{3'h4, 2'h1, 4'h9, 8'h14},
                 '{3'h2, 2'h3, 4'h0, 8'h14}, '{3'h1, 2'h0, 4'h5, 8'h06}};
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        run_wait(6, 7);
        foreach (rows[i]) begin
            fuses <= '{rows[i].lvl, rows[i].startup_time_fuse, rows[i].cks};
            por();
            run_wait(rows[i].target, rows[i].target + 1);
            rd(CAUSE_IO_ADDR, 8'h01);
            rd(CAUSE_DATA_ADDR, 8'h01);
            chk("refEnable", refEnable, 8'(rows[i].lvl != 3'h7));
        end
        fuses <= '{3'h6, 2'h0, 4'h5};
        por();
        run_wait(6, 7);
        rd(IRQ_STATUS_ADDR, 8'h01);
        wr(IRQ_ENABLE_ADDR, 8'h01);
        @(negedge ref_clk);
        chk("irq", irq, 8'h01);
        rd(IRQ_ENABLE_ADDR, 8'h01);
        wr(IRQ_STATUS_ADDR, 8'h00);
        rd(IRQ_STATUS_ADDR, 8'h01);
        wr(IRQ_CLEAR_ADDR, 8'h01);
        repeat (2) @(negedge ref_clk);
        chk("irq", irq, 8'h00);
        rd(IRQ_STATUS_ADDR, 8'h00);
        rd(IRQ_CLEAR_ADDR, 8'h00);
        rd(8'h40, 8'h00);
        wr(CAUSE_IO_ADDR, 8'hFF);
        rd(CAUSE_IO_ADDR, 8'h01);
        wr(CAUSE_IO_ADDR, 8'h00);
        rd(CAUSE_IO_ADDR, 8'h00);
        @(posedge ref_clk);
        watchdogTimeout <= 1'b1;
        @(posedge ref_clk);
        watchdogTimeout <= 1'b0;
        @(negedge ref_clk);
        chk("watchdogResetPulse", watchdogResetPulse, 8'h01);
        chk("coreResetN", coreResetN, 8'h00);
        @(negedge ref_clk);
        chk("watchdogResetPulse", watchdogResetPulse, 8'h00);
        run_wait(5, 7);
        rd(CAUSE_IO_ADDR, 8'h08);
        rd(IRQ_STATUS_ADDR, 8'h09);
        wr(CAUSE_IO_ADDR, 8'h00);
        // set and clear of the same flag land on one edge
        @(posedge ref_clk);
        watchdogTimeout <= 1'b1;
        regWr    <= 1'b1;
        regAddr  <= CAUSE_IO_ADDR;
        regWdata <= 8'h00;
        @(posedge ref_clk);
        watchdogTimeout <= 1'b0;
        regWr <= 1'b0;
        run_wait(5, 8);
        rd(CAUSE_IO_ADDR, 8'h08);
        wr(CAUSE_IO_ADDR, 8'h00);
        pinResetEnable <= 1'b1;
        hold_src(20, 1'b1, 8'h01);
        repeat (10) @(posedge ref_clk);
        pinResetEnable <= 1'b0;
        hold_src(60, 1'b1, 8'h01);
        // filter must drain before the pin is enabled again
        repeat (5) @(posedge ref_clk);
        pinResetEnable <= 1'b1;
        hold_src(60, 1'b1, 8'h00);
        run_wait(6, 12);
        rd(CAUSE_IO_ADDR, 8'h02);
        // clear written while the pin still holds reset
        @(posedge ref_clk);
        resetPinN <= 1'b0;
        repeat (50) @(posedge ref_clk);
        wr(CAUSE_IO_ADDR, 8'h00);
        rd(CAUSE_IO_ADDR, 8'h02);
        @(posedge ref_clk);
        resetPinN <= 1'b1;
        run_wait(6, 12);
        wr(CAUSE_IO_ADDR, 8'h00);
        hold_src(40, 1'b0, 8'h01);
        repeat (10) @(posedge ref_clk);
        hold_src(120, 1'b0, 8'h00);
        run_wait(6, 12);
        rd(CAUSE_IO_ADDR, 8'h04);
        fuses <= '{UV_OFF_CODE, 2'h0, 4'h5};
        por();
        run_wait(6, 7);
        rd(CAUSE_IO_ADDR, 8'h01);
        hold_src(120, 1'b0, 8'h01);
        chk("refEnable", refEnable, 8'h00);
        comparatorRefSelect <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("refEnable", refEnable, 8'h01);
        comparatorRefSelect <= 1'b0;
        adcEnable <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("refEnable", refEnable, 8'h01);
        adcEnable <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("refEnable", refEnable, 8'h00);
        // frozen enable must not advance the stretch
        por();
        clkEn <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clkEn <= 1'b1;
        run_wait(6, 7);
        give_verdict();
    end
endmodule : rsq_reset_sequencer_tb_top
